// ==== design/rx_sig_pkg.sv ====
package rx_sig_pkg;
    // Register port map
    localparam logic [8:0] TIMER_IRQ_ADDR = 9'h008;
    localparam logic [8:0] BUS_CFG_ADDR   = 9'h0D0;
    localparam logic [8:0] SIG_CFG_ADDR   = 9'h0D7;
    localparam logic [8:0] STACK_ADDR     = 9'h0DA;
    localparam logic [8:0] CHCTL_BASE     = 9'h180;
    localparam logic [8:0] STORE_BASE     = 9'h1A0;
    // Field positions
    localparam int CFG_TRANSP   = 0;
    localparam int CFG_FREEZE   = 1;
    localparam int CFG_DEBOUNCE = 2;
    localparam int CFG_UNICODE  = 3;
    localparam int CFG_EVERY_MF = 4;
    localparam int BUS_EMBED    = 0;
    localparam int BUS_T1       = 1;
    localparam int CHCTL_STK_EN = 0;
    localparam int IRQ_SIG_BIT  = 0;
    localparam int STK_MORE     = 7;
    localparam int STK_WORD     = 6;
    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    // Sizes and frame layout
    localparam int NUM_TS_DEF  = 32;
    localparam int T1_CHANNELS = 24;
    localparam int E1_CHANNELS = 30;
    localparam logic [4:0] TS_IDLE_A  = 5'h00;
    localparam logic [4:0] TS_IDLE_B  = 5'h10;
    localparam logic [4:0] TS_FBIT    = 5'h1A;
    localparam logic [2:0] FBIT_POS   = 3'h0;
    localparam logic [2:0] ROB_POS    = 3'h7;
    localparam logic [2:0] ROB_FRAME  = 3'h5;
    localparam logic [1:0] ROB_LAST   = 2'h3;
    // Processor register request
    typedef struct packed {
        logic [8:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } reg_req_t;
    // Received signaling for one timeslot
    typedef struct packed {
        logic [4:0] ts;
        logic [3:0] abcd;
    } sig_word_t;
    // Which half of a stack entry the next read returns
    typedef enum logic [1:0] {
        WORD_CH   = 2'b01,
        WORD_ABCD = 2'b10
    } stack_word_t;
endpackage : rx_sig_pkg

// ==== design/rx_signaling_buffer_stack.sv ====
`timescale 1ns/1ps
`default_nettype none

// Three-stage filtered synchroniser for slow levels
module sig_level_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,     // Destination clock
    input  wire logic         rst_n_i,   // Async reset, low
    input  wire logic [W-1:0] d_i,       // Foreign level
    output var  logic [W-1:0] q_o        // Filtered level
);
    logic [W-1:0] s1_q, s2_q, s3_q;

    // Accept a change once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q_o  <= '0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) q_o <= s3_q;
        end
    end
endmodule : sig_level_sync

module rx_signaling_buffer_stack
    import rx_sig_pkg::*;
#(
    parameter int NUM_TS      = rx_sig_pkg::NUM_TS_DEF,
    parameter int STACK_DEPTH = rx_sig_pkg::E1_CHANNELS
) (
    input  wire logic                  clock_i,            // Core clock
    input  wire logic                  reset_n_i,          // Async reset
    input  wire rx_sig_pkg::reg_req_t  reg_req_i,          // Register access
    output var  logic [7:0]            reg_rdata_o,        // Read data
    input  wire rx_sig_pkg::sig_word_t rx_sig_i,           // Rx signaling
    input  wire logic                  rx_sig_valid_i,     // Rx sig strobe
    output var  logic                  sig_irq_o,          // Signaling irq
    input  wire logic                  rx_bus_clock_in_i,  // Bus clock
    input  wire logic                  rx_frame_sync_i,    // Frame sync
    input  wire logic                  rx_multiframe_sync_i, // MF sync
    input  wire logic                  rx_pcm_in_i,        // PCM from slip
    input  wire logic                  rx_fbit_i,          // T1 F-bit
    output var  logic                  rx_pcm_out_o,       // PCM output
    output var  logic                  rx_signaling_out_o  // ABCD output
);
    import rx_sig_pkg::*;

    if (NUM_TS != NUM_TS_DEF || STACK_DEPTH < E1_CHANNELS
        || STACK_DEPTH > NUM_TS) begin : g_bad
        $error("unsupported store or stack size");
    end

    // ---------------- Core domain ----------------
    logic [7:0]        store_q [NUM_TS];
    logic [7:0]        chctl_q [NUM_TS];
    logic [7:0]        cfg_q, bus_cfg_q, irq_stat_q, rdata_q;
    logic [NUM_TS-1:0] pend_q;
    logic              changed_q, mf_prev_q;
    stack_word_t       word_q;
    logic [4:0]        stk_ch_q, scan_q;
    sig_word_t         buf_q [2];
    logic              wp_q, rp_q, hs_req_q;
    logic [1:0]        cnt_q;
    sig_word_t         hs_data_q;
    logic              ack_lvl, mf_lvl;
    logic [4:0]        low_ch;

    // Register decode
    wire [8:0] addr      = reg_req_i.addr;
    wire [4:0] idx       = addr[4:0];
    wire in_store        = addr[8:5] == STORE_BASE[8:5];
    wire in_chctl        = addr[8:5] == CHCTL_BASE[8:5];
    wire wr_store        = reg_req_i.wr & in_store;
    wire wr_chctl        = reg_req_i.wr & in_chctl;
    wire wr_cfg          = reg_req_i.wr & (addr == SIG_CFG_ADDR);
    wire wr_bus          = reg_req_i.wr & (addr == BUS_CFG_ADDR);
    wire rd_stack        = reg_req_i.rd & (addr == STACK_ADDR);
    wire rd_irq          = reg_req_i.rd & (addr == TIMER_IRQ_ADDR);

    // Receiver update and change qualification
    wire [4:0] rx_ts     = rx_sig_i.ts;
    wire [3:0] old_rx    = store_q[rx_ts][3:0];
    wire [3:0] old_out   = store_q[rx_ts][7:4];
    wire stable          = ~cfg_q[CFG_DEBOUNCE]
                           | (rx_sig_i.abcd == old_rx);
    wire out_upd         = rx_sig_valid_i & ~cfg_q[CFG_FREEZE] & stable
                           & (rx_sig_i.abcd != old_out);
    wire stk_set         = out_upd & chctl_q[rx_ts][CHCTL_STK_EN];

    // Stack bookkeeping
    wire pend_any        = |pend_q;
    wire [NUM_TS-1:0] ch_hot  = NUM_TS'(1) << stk_ch_q;
    wire [NUM_TS-1:0] set_hot = stk_set ? NUM_TS'(1) << rx_ts : '0;
    wire pop_entry       = rd_stack & (word_q == WORD_ABCD);
    wire [NUM_TS-1:0] clr_hot = pop_entry ? ch_hot : '0;
    wire more_after      = |(pend_q & ~ch_hot);
    wire [7:0] stk_rd    = (word_q == WORD_ABCD)
                           ? {more_after, 3'h4, store_q[stk_ch_q][7:4]}
                           : {pend_any, 2'h0, low_ch};

    // Multiframe boundary from link domain
    wire mf_end          = mf_lvl != mf_prev_q;
    wire t1_mode         = bus_cfg_q[BUS_T1];
    wire sig_event       = mf_end & (changed_q
                           | (cfg_q[CFG_EVERY_MF] & t1_mode));

    // Read data selection
    wire [7:0] rd_mux    = in_store ? store_q[idx]
                         : in_chctl ? chctl_q[idx]
                         : (addr == SIG_CFG_ADDR) ? cfg_q
                         : (addr == BUS_CFG_ADDR) ? bus_cfg_q
                         : (addr == TIMER_IRQ_ADDR) ? irq_stat_q
                         : rd_stack ? stk_rd : REG_RESET;

    // Scanner feeds buffer, sender drains it
    wire buf_full        = cnt_q == 2'd2;
    wire buf_empty       = cnt_q == 2'd0;
    wire push            = ~buf_full;
    wire send_idle       = hs_req_q == ack_lvl;
    wire pop             = ~buf_empty & send_idle;
    wire sig_word_t scan_word = '{ts: scan_q, abcd: store_q[scan_q][7:4]};

    // Lowest pending channel
    always_comb begin
        low_ch = '0;
        for (int i = NUM_TS - 1; i >= 0; i--) begin
            if (pend_q[i]) low_ch = 5'(i);
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NUM_TS; i++) store_q[i] <= REG_RESET;
        end else begin
            for (int i = 0; i < NUM_TS; i++) begin
                if (wr_store && idx == 5'(i)) begin
                    store_q[i] <= reg_req_i.wdata;
                end else if (rx_sig_valid_i && rx_ts == 5'(i)) begin
                    store_q[i] <= {out_upd ? rx_sig_i.abcd : old_out,
                                   rx_sig_i.abcd};
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NUM_TS; i++) chctl_q[i] <= REG_RESET;
            cfg_q     <= REG_RESET;
            bus_cfg_q <= REG_RESET;
        end else begin
            if (wr_chctl) chctl_q[idx] <= reg_req_i.wdata;
            if (wr_cfg) cfg_q <= reg_req_i.wdata;
            if (wr_bus) bus_cfg_q <= reg_req_i.wdata;
        end
    end

    // One pending bit per channel, set wins
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) pend_q <= '0;
        else pend_q <= (pend_q & ~clr_hot) | set_hot;
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            word_q   <= WORD_CH;
            stk_ch_q <= '0;
        end else if (rd_stack) begin
            case (word_q)
                WORD_CH: begin
                    if (pend_any) begin
                        stk_ch_q <= low_ch;
                        word_q   <= WORD_ABCD;
                    end
                end
                WORD_ABCD: word_q <= WORD_CH;
                default:   word_q <= WORD_CH;
            endcase
        end
    end

    // Flag, cleared on read, set wins
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            changed_q  <= 1'b0;
            mf_prev_q  <= 1'b0;
            irq_stat_q <= REG_RESET;
            rdata_q    <= REG_RESET;
        end else begin
            changed_q <= out_upd | (changed_q & ~mf_end);
            mf_prev_q <= mf_lvl;
            irq_stat_q[IRQ_SIG_BIT] <= sig_event
                | (irq_stat_q[IRQ_SIG_BIT] & ~rd_irq);
            if (reg_req_i.rd) rdata_q <= rd_mux;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign sig_irq_o   = irq_stat_q[IRQ_SIG_BIT];

    // Two-entry buffer toward the link handshake
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            buf_q[0]  <= '0;
            buf_q[1]  <= '0;
            wp_q      <= 1'b0;
            rp_q      <= 1'b0;
            cnt_q     <= 2'd0;
            scan_q    <= '0;
            hs_req_q  <= 1'b0;
            hs_data_q <= '0;
        end else begin
            if (push) begin
                buf_q[wp_q] <= scan_word;
                wp_q        <= ~wp_q;
                scan_q      <= scan_q + 5'd1;
            end
            if (pop) begin
                hs_data_q <= buf_q[rp_q];
                hs_req_q  <= ~hs_req_q;
                rp_q      <= ~rp_q;
            end
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
        end
    end

    // ---------------- Link domain ----------------
    logic [3:0] shadow_q [NUM_TS];
    logic       ack_q, mf_tgl_q, fs_q, mfs_q;
    logic [7:0] bit_q;
    logic [2:0] r6_q;
    logic [1:0] rob_q;
    logic       req_lvl;
    logic [2:0] lcfg;

    sig_level_sync #(.W(1)) u_req (
        .clk_i   (rx_bus_clock_in_i),
        .rst_n_i (reset_n_i),
        .d_i     (hs_req_q),
        .q_o     (req_lvl)
    );
    sig_level_sync #(.W(3)) u_cfg (
        .clk_i   (rx_bus_clock_in_i),
        .rst_n_i (reset_n_i),
        .d_i     ({cfg_q[CFG_TRANSP], bus_cfg_q[BUS_T1],
                   bus_cfg_q[BUS_EMBED]}),
        .q_o     (lcfg)
    );
    sig_level_sync #(.W(1)) u_ack (
        .clk_i   (clock_i),
        .rst_n_i (reset_n_i),
        .d_i     (ack_q),
        .q_o     (ack_lvl)
    );
    sig_level_sync #(.W(1)) u_mf (
        .clk_i   (clock_i),
        .rst_n_i (reset_n_i),
        .d_i     (mf_tgl_q),
        .q_o     (mf_lvl)
    );

    // Timeslot position and mapping
    wire [4:0] ts        = bit_q[7:3];
    wire [2:0] bp        = bit_q[2:0];
    wire l_t1            = lcfg[1];
    wire embed_act       = lcfg[0] & l_t1;
    wire assigned        = ts != TS_IDLE_A && ts != TS_IDLE_B
                           && ts < TS_FBIT;
    wire [3:0] sig_nib   = shadow_q[ts];
    wire rob_slot        = l_t1 & ~lcfg[2] & (r6_q == ROB_FRAME)
                           & (bp == ROB_POS);
    wire new_word        = req_lvl != ack_q;

    // Sample syncs, count bits and frames
    always_ff @(posedge rx_bus_clock_in_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fs_q     <= 1'b0;
            mfs_q    <= 1'b0;
            bit_q    <= '0;
            r6_q     <= '0;
            rob_q    <= '0;
            mf_tgl_q <= 1'b0;
        end else begin
            fs_q  <= rx_frame_sync_i;
            mfs_q <= rx_multiframe_sync_i;
            bit_q <= fs_q ? 8'h00 : bit_q + 8'h01;
            if (mfs_q) begin
                r6_q     <= '0;
                rob_q    <= '0;
                mf_tgl_q <= ~mf_tgl_q;
            end else if (fs_q) begin
                r6_q <= (r6_q == ROB_FRAME) ? 3'h0 : r6_q + 3'h1;
                if (r6_q == ROB_FRAME && rob_q != ROB_LAST) begin
                    rob_q <= rob_q + 2'h1;
                end
            end
        end
    end

    // Shadow copy of outgoing nibbles
    always_ff @(posedge rx_bus_clock_in_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NUM_TS; i++) shadow_q[i] <= '0;
            ack_q <= 1'b0;
        end else if (new_word) begin
            shadow_q[hs_data_q.ts] <= hs_data_q.abcd;
            ack_q <= req_lvl;
        end
    end

    always_ff @(posedge rx_bus_clock_in_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_pcm_out_o       <= 1'b1;
            rx_signaling_out_o <= 1'b1;
        end else begin
            if (embed_act && ts == TS_FBIT && bp == FBIT_POS)
                rx_pcm_out_o <= rx_fbit_i;
            else if (embed_act && !assigned)
                rx_pcm_out_o <= 1'b1;
            else if (rob_slot)
                rx_pcm_out_o <= sig_nib[~rob_q];
            else
                rx_pcm_out_o <= rx_pcm_in_i;
            rx_signaling_out_o <= bp[2] ? sig_nib[~bp[1:0]] : 1'b1;
        end
    end

    // ---------------- Checks ----------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_first_read;
        rd_stack && word_q == WORD_CH && pend_any;
    endsequence
    sequence s_second_read;
        rd_stack && word_q == WORD_ABCD;
    endsequence

    chk_word_order: assert property (
        s_first_read |=> word_q == WORD_ABCD)
        else $error("stack word order broken");
    chk_word_return: assert property (
        s_second_read |=> word_q == WORD_CH)
        else $error("stack word not returned");
    chk_last_pop: assert property (
        s_second_read ##0 (pend_q == ch_hot && !stk_set) |=> !pend_any)
        else $error("last entry not removed");
    chk_change_irq: assert property (
        mf_end && changed_q |=> sig_irq_o)
        else $error("signaling flag missing");
    chk_every_mf: assert property (
        mf_end && cfg_q[CFG_EVERY_MF] && t1_mode |=> irq_stat_q[0])
        else $error("per multiframe irq missing");
    chk_stack_rec: assert property (
        stk_set |=> pend_q[$past(rx_ts)])
        else $error("change not recorded");
    chk_stack_gate: assert property (
        rx_sig_valid_i && !chctl_q[rx_ts][0] && !pend_q[rx_ts]
        |=> !pend_q[$past(rx_ts)])
        else $error("disabled channel recorded");
    chk_cpu_write: assert property (
        wr_store |=> store_q[$past(idx)] == $past(reg_req_i.wdata))
        else $error("store write lost");
    chk_freeze_hold: assert property (
        rx_sig_valid_i && cfg_q[CFG_FREEZE] && !wr_store
        |=> store_q[$past(rx_ts)][7:4] == $past(old_out))
        else $error("frozen signaling changed");
    chk_fbit_embed: assert property (
        @(posedge rx_bus_clock_in_i) disable iff (!reset_n_i)
        embed_act && ts == TS_FBIT && bp == FBIT_POS
        |=> rx_pcm_out_o == $past(rx_fbit_i))
        else $error("framing bit misplaced");
    chk_idle_slot: assert property (
        @(posedge rx_bus_clock_in_i) disable iff (!reset_n_i)
        embed_act && ts == TS_IDLE_B |=> rx_pcm_out_o)
        else $error("idle timeslot carries data");
endmodule : rx_signaling_buffer_stack

`default_nettype wire

// ==== test/pcm_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Backplane side: frame syncs, PCM source and capture of device outputs
module pcm_bus_model #(
    parameter int MF_FRAMES = 12
) (
    input  wire logic         bus_clk_i,   // Link clock
    input  wire logic         reset_n_i,   // Async reset
    input  wire logic         fbit_i,      // Framing bit level to send
    input  wire logic         pcm_out_i,   // PCM from device
    input  wire logic         sig_out_i,   // ABCD from device
    output var  logic         fs_o,        // Frame sync
    output var  logic         mfs_o,       // Multiframe sync
    output var  logic         pcm_o,       // PCM to device
    output var  logic         fbit_o,      // Framing bit to device
    output var  logic [255:0] pcm_frame_o, // Last captured PCM frame
    output var  logic [255:0] sig_frame_o  // Last captured ABCD frame
);
    logic [7:0] pos_q;
    int         frame_q;
    logic [7:0] cap_pos;

    // Output bit k shows three link edges after the sync edge
    assign cap_pos = pos_q - 8'h03;

    always @(posedge bus_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pos_q   <= 8'h00;
            frame_q <= 0;
            fs_o    <= 1'b0;
            mfs_o   <= 1'b0;
            pcm_o   <= 1'b0;
            fbit_o  <= 1'b0;
        end else begin
            pos_q  <= pos_q + 8'h01;
            fs_o   <= (pos_q == 8'hFF);
            mfs_o  <= (pos_q == 8'hFF) && (frame_q == MF_FRAMES - 1);
            pcm_o  <= pos_q[0] ^ pos_q[3];
            fbit_o <= fbit_i;
            if (pos_q == 8'hFF) begin
                frame_q <= (frame_q + 1) % MF_FRAMES;
            end
            pcm_frame_o[cap_pos] <= pcm_out_i;
            sig_frame_o[cap_pos] <= sig_out_i;
        end
    end
endmodule : pcm_bus_model

`default_nettype wire

// ==== test/rx_signaling_buffer_stack_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module rx_signaling_buffer_stack_test;
    import rx_sig_pkg::*;
    logic                clock_i = 1'b0;
    logic                bus_clk = 1'b0;
    logic                reset_n = 1'b0;
    reg_req_t            reg_req = '0;
    sig_word_t           sig_word = '0;
    logic                sig_valid = 1'b0;
    logic                fbit_level = 1'b0;
    logic [7:0]          rdata;
    logic                irq, fs, mfs, pcm_in, fbit, pcm_out, sig_out;
    logic [255:0]        pcm_frame, sig_frame;
    int                  fail_count = 0;
    int                  num_checks = 0;
    int                  cycles = 0;

    // Core and link clocks, unrelated phase
    always #20 clock_i = ~clock_i;
    initial #3 forever #7.5 bus_clk = ~bus_clk;

    rx_signaling_buffer_stack dut_u (
        .clock_i(clock_i), .reset_n_i(reset_n), .reg_req_i(reg_req),
        .reg_rdata_o(rdata), .rx_sig_i(sig_word),
        .rx_sig_valid_i(sig_valid), .sig_irq_o(irq),
        .rx_bus_clock_in_i(bus_clk), .rx_frame_sync_i(fs),
        .rx_multiframe_sync_i(mfs), .rx_pcm_in_i(pcm_in),
        .rx_fbit_i(fbit), .rx_pcm_out_o(pcm_out),
        .rx_signaling_out_o(sig_out));

    pcm_bus_model bus_u (
        .bus_clk_i(bus_clk), .reset_n_i(reset_n), .fbit_i(fbit_level),
        .pcm_out_i(pcm_out), .sig_out_i(sig_out), .fs_o(fs),
        .mfs_o(mfs), .pcm_o(pcm_in), .fbit_o(fbit),
        .pcm_frame_o(pcm_frame), .sig_frame_o(sig_frame));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // Hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            $display("FAIL t=%0t timeout", $time);
            report_and_stop();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_req <= '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
        @(posedge clock_i);
        reg_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        reg_req <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        @(posedge clock_i);
        reg_req.rd <= 1'b0;
        @(posedge clock_i);
        #1;
        chk(rdata, exp, "register read");
    endtask : rd

    task automatic sig_in(input logic [4:0] t, input logic [3:0] v);
        @(posedge clock_i);
        sig_word  <= '{ts: t, abcd: v};
        sig_valid <= 1'b1;
        @(posedge clock_i);
        sig_valid <= 1'b0;
    endtask : sig_in

    task automatic wait_irq(input logic exp, input int lim);
        int n;
        n = 0;
        while (irq !== exp && n < lim) begin
            @(posedge clock_i);
            n++;
        end
        #1;
        chk({7'h00, irq}, {7'h00, exp}, "interrupt line");
    endtask : wait_irq

    function automatic logic [3:0] abcd_of(input logic [4:0] t);
        return {t[3:1], 1'b1};
    endfunction : abcd_of

    // Main sequence
    initial begin
        logic [8:0] base [9];
        logic [7:0] got;
        logic [31:0] seen;
        logic        e;
        logic [3:0]  nib;
        base = '{9'h008, 9'h0D0, 9'h0D7, 9'h0DA, 9'h180, 9'h19F,
                 9'h1A0, 9'h1BF, 9'h001};
        repeat (5) @(posedge clock_i);
        reset_n <= 1'b1;
        foreach (base[i]) rd(base[i], 8'h00);
        wr(9'h008, 8'hFF);
        rd(9'h008, 8'h00);
        wr(9'h0FF, 8'h5A);
        rd(9'h0FF, 8'h00);
        wr(9'h0D7, 8'h1F);
        rd(9'h0D7, 8'h1F);
        wr(9'h0D7, 8'h00);
        for (int n = 0; n < 32; n++) begin
            wr(STORE_BASE + 9'(n), 8'(n * 7 + 8'h11));
            rd(STORE_BASE + 9'(n), 8'(n * 7 + 8'h11));
            wr(STORE_BASE + 9'(n), 8'h00);
            wr(CHCTL_BASE + 9'(n), {7'h00, n < 30});
        end
        $display("test registers done");
        // Frozen entry takes the received nibble only
        wr(SIG_CFG_ADDR, 8'h02);
        sig_in(5'd4, 4'hA);
        rd(STORE_BASE + 9'd4, 8'h0A);
        wr(SIG_CFG_ADDR, 8'h00);
        sig_in(5'd3, 4'h2);
        for (int n = 0; n < 32; n++) sig_in(5'(n), abcd_of(5'(n)));
        rd(STORE_BASE + 9'd3, 8'h33);
        repeat (1300) @(posedge clock_i);
        wait_irq(1'b1, 10);
        seen = '0;
        for (int i = 0; i < 30; i++) begin
            @(posedge clock_i);
            reg_req <= '{addr: STACK_ADDR, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
            @(posedge clock_i);
            reg_req.rd <= 1'b0;
            @(posedge clock_i);
            #1;
            got = rdata;
            e = got[7:5] === 3'b100 && got[4:0] < 30 && !seen[got[4:0]];
            chk({7'h00, e}, 8'h01, "stack first word");
            seen[got[4:0]] = 1'b1;
            rd(STACK_ADDR, {i < 29, 3'b100, abcd_of(got[4:0])});
        end
        rd(STACK_ADDR, 8'h00);
        rd(TIMER_IRQ_ADDR, 8'h01);
        rd(TIMER_IRQ_ADDR, 8'h00);
        $display("test change stack done");
        wr(BUS_CFG_ADDR, 8'h02);
        rd(TIMER_IRQ_ADDR, 8'h00);
        wr(SIG_CFG_ADDR, 8'h10);
        wait_irq(1'b1, 3000);
        wr(SIG_CFG_ADDR, 8'h00);
        rd(TIMER_IRQ_ADDR, 8'h01);
        repeat (1300) @(posedge clock_i);
        wait_irq(1'b0, 1);
        $display("test every multiframe done");
        wr(BUS_CFG_ADDR, 8'h03);
        for (int fb = 0; fb < 2; fb++) begin
            fbit_level <= fb[0];
            repeat (600) @(posedge clock_i);
            for (int b = 0; b < 256; b++) begin
                if (b / 8 == 0 || b / 8 == 16 || b / 8 >= 26) begin
                    e = (b == 26 * 8) ? fb[0] : 1'b1;
                    chk({7'h00, pcm_frame[b]}, {7'h00, e}, "pcm bit");
                end else if (b % 8 != 7) begin
                    // Assigned slots pass the bus pattern through
                    e = 1'(b + 1) ^ 1'((b + 1) >> 3);
                    chk({7'h00, pcm_frame[b]}, {7'h00, e}, "pcm in");
                end
                if (b / 8 >= 1 && b / 8 <= 15) begin
                    nib = abcd_of(5'(b / 8));
                    e = (b % 8 < 4) ? 1'b1 : nib[7 - b % 8];
                    chk({7'h00, sig_frame[b]}, {7'h00, e}, "abcd");
                end
            end
        end
        $display("test embedded framing done");
        report_and_stop();
    end
endmodule : rx_signaling_buffer_stack_test

`default_nettype wire
